// [shared/bms_pkg.sv]
// Constants and carrier types for the boot mode selector and vendor command decoder
package bms_pkg;
   // -----------------------------------------
   // Signatures and command codes
   // -----------------------------------------
   localparam logic [15:0] BMS_SIG_LEGACY = 16'h4D4D;
   localparam logic [15:0] BMS_SIG_CURRENT = 16'h534B;
   localparam logic [7:0] BMS_SUB_CFG = 8'h26;
   localparam logic [7:0] BMS_SUB_BOARD = 8'h27;
   localparam logic [7:0] BMS_SRC_EXT_MEM = 8'h02;
   localparam logic [15:0] BMS_START_ADDR = 16'h0000;
   localparam logic [7:0] BMS_SIG_ADDR = 8'h04;
   localparam logic [7:0] BMS_ZERO_BYTE = 8'h00;
   localparam logic [15:0] BMS_ZERO_ID = 16'h0000;
   localparam logic [31:0] BMS_MAX_XFER = 32'h0000_00FF;
   // -----------------------------------------
   // Wrapper layout (byte positions)
   // -----------------------------------------
   localparam int BMS_CBW_BYTES = 31;
   localparam int BMS_LEN_LO = 8;
   localparam int BMS_FLAG_BYTE = 12;
   localparam int BMS_DIR_BIT = 7;
   localparam int BMS_CB_BASE = 15;
   localparam int BMS_CB_BYTES = 16;
   localparam int BMS_RSV_LO = 6;
   localparam int BMS_RSV_HI = 15;
   // -----------------------------------------
   // Types
   // -----------------------------------------
   typedef enum logic [1:0] {
      BMS_MODE_COMPAT = 2'b00,
      BMS_MODE_NORMAL = 2'b01,
      BMS_MODE_NOMEM = 2'b11,
      BMS_MODE_TEST = 2'b10
   } bms_mode_t;
   typedef enum logic [1:0] {
      BMS_ST_PROBE = 2'b00,
      BMS_ST_DECIDE = 2'b01,
      BMS_ST_RUN = 2'b11
   } bms_state_t;
   typedef enum logic [1:0] {
      BMS_OP_NONE = 2'b00,
      BMS_OP_CFG_LOAD = 2'b01,
      BMS_OP_CFG_READ = 2'b10,
      BMS_OP_BOARD = 2'b11
   } bms_op_t;
   typedef struct packed {
      logic valid;
      logic present;
      logic [15:0] signature;
      logic [7:0] cmd_sig;
   } bms_probe_t;
   typedef struct packed {
      logic valid;
      logic pass;
      bms_op_t op;
      logic [7:0] length;
   } bms_cmd_t;
endpackage

// [tb/bms_host_model.sv]
// Host-side model that sends bulk command wrappers one byte a cycle, or one byte every other cycle when gapped
module bms_host_model (
   // Clock
   input wire logic clock,
   // Wrapper byte stream
   output logic cbw_valid,
   output logic cbw_first,
   output logic [7:0] cbw_byte
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle stream at time zero
   initial begin
      cbw_valid = 1'b0;
      cbw_first = 1'b0;
      cbw_byte = 8'hA5;
   end

   // ----------------------------------------
   // Frame sender
   // ----------------------------------------
   // whole wrapper sent
   task automatic send(input logic [247:0] frame, input bit gapped);
      for (int i = 0; i < 31; i++) begin
         @(posedge clock);
         #1;
         if (gapped && i > 0) begin
            // Slow host leaves an idle beat with a changed byte
            cbw_valid = 1'b0;
            cbw_byte = ~cbw_byte;
            @(posedge clock);
            #1;
         end
         cbw_valid = 1'b1;
         cbw_first = (i == 0);
         cbw_byte = frame[i*8 +: 8];
      end
      @(posedge clock);
      #1;
      cbw_valid = 1'b0;
      cbw_first = 1'b0;
      cbw_byte = ~cbw_byte; // Released bus never shows the last byte
   endtask
endmodule

// [tb/tb_bms_top.sv]
// Self-checking bench for the boot mode selector and command decoder
module tb_bms_top;
   timeunit 1ns;
   timeprecision 100ps;
   import bms_pkg::*;

   localparam logic [7:0] CSIG = 8'h24;
   typedef struct packed {
      logic pin_n;
      logic present;
      logic [15:0] sig;
      bms_mode_t exp;
   } bms_mrow_t;
   typedef struct packed {
      logic [7:0] sig;
      logic [7:0] sub;
      logic [7:0] b2;
      logic [7:0] src;
      logic [15:0] addr;
      logic [7:0] rsv;
      logic [31:0] len;
      logic dir;
      bms_op_t op;
      logic pass;
   } bms_crow_t;

   logic clock, rst, drive_reset_line_n, cbw_valid, cbw_first, mode_valid, pin_control_mode;
   logic [7:0] cbw_byte;
   logic [15:0] usb_vendor_id, usb_product_id, usb_release_id;
   bms_probe_t probe;
   bms_mode_t mode;
   bms_cmd_t cmd;
   int errors, checks_done;
   bms_crow_t r;

   bms_mrow_t mrows[5] = '{'{1'b0, 1'b1, 16'h534B, BMS_MODE_TEST}, '{1'b1, 1'b0, 16'h4D4D, BMS_MODE_NOMEM},
      '{1'b1, 1'b1, 16'h4D4D, BMS_MODE_COMPAT}, '{1'b1, 1'b1, 16'h534B, BMS_MODE_NORMAL},
      '{1'b1, 1'b1, 16'h4D4C, BMS_MODE_TEST}};
   bms_crow_t crows[11] = '{
      '{CSIG, 8'h26, 8'h00, 8'h02, 16'h0000, 8'h00, 32'h0000_00FF, 1'b1, BMS_OP_CFG_READ, 1'b1},
      '{CSIG, 8'h26, 8'h00, 8'h02, 16'h0000, 8'h00, 32'h0000_0000, 1'b0, BMS_OP_CFG_LOAD, 1'b1},
      '{CSIG, 8'h26, 8'h00, 8'h02, 16'h0000, 8'h00, 32'h0000_0100, 1'b0, BMS_OP_CFG_LOAD, 1'b0},
      '{8'h25, 8'h26, 8'h00, 8'h02, 16'h0000, 8'h00, 32'h0000_0000, 1'b1, BMS_OP_NONE, 1'b0},
      '{CSIG, 8'h28, 8'h00, 8'h02, 16'h0000, 8'h00, 32'h0000_0000, 1'b1, BMS_OP_NONE, 1'b0},
      '{CSIG, 8'h26, 8'h00, 8'h01, 16'h0000, 8'h00, 32'h0000_0000, 1'b1, BMS_OP_CFG_READ, 1'b0},
      '{CSIG, 8'h26, 8'h00, 8'h02, 16'h0100, 8'h00, 32'h0000_0000, 1'b1, BMS_OP_CFG_READ, 1'b0},
      '{CSIG, 8'h26, 8'h01, 8'h02, 16'h0000, 8'h00, 32'h0000_0000, 1'b0, BMS_OP_CFG_LOAD, 1'b0},
      '{CSIG, 8'h26, 8'h00, 8'h02, 16'h0000, 8'h80, 32'h0000_0000, 1'b1, BMS_OP_CFG_READ, 1'b0},
      '{CSIG, 8'h27, 8'h00, 8'h00, 16'h0000, 8'h01, 32'h0000_0000, 1'b1, BMS_OP_BOARD, 1'b1},
      '{CSIG, 8'h27, 8'h00, 8'h00, 16'h0000, 8'h00, 32'h0000_0000, 1'b0, BMS_OP_BOARD, 1'b1}};

   bms_top dut_u (.clock(clock), .rst(rst), .probe(probe), .drive_reset_line_n(drive_reset_line_n),
      .cbw_valid(cbw_valid), .cbw_first(cbw_first), .cbw_byte(cbw_byte), .mode(mode), .mode_valid(mode_valid),
      .usb_vendor_id(usb_vendor_id), .usb_product_id(usb_product_id), .usb_release_id(usb_release_id),
      .pin_control_mode(pin_control_mode), .cmd(cmd));
   bms_host_model host_u (.clock(clock), .cbw_valid(cbw_valid), .cbw_first(cbw_first), .cbw_byte(cbw_byte));

   // Free-running 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("Checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bounded wait on mode_valid or the command pulse
   task automatic wait_flag(input bit on_cmd);
      for (int n = 0; n < 8; n++) begin
         @(posedge clock);
         #1;
         if ((on_cmd ? cmd.valid : mode_valid) === 1'b1)
            return;
      end
      errors++;
      $display("MISMATCH wait expected 1 seen 0");
      finish_test();
   endtask

   task automatic start(input logic pin_n, input logic present, input logic [15:0] sig);
      @(posedge clock);
      #1;
      rst = 1'b1;
      probe = '{1'b0, present, sig, CSIG};
      drive_reset_line_n = pin_n;
      repeat (4) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk("mode_valid_rst", 1'b0, mode_valid);
      chk("cmd_rst", 12'h000, cmd);
      probe.valid = 1'b1;
      wait_flag(1'b0);
   endtask

   // Builds a wrapper: length little endian in bytes 8..11, block at 15
   function automatic logic [247:0] mk(bms_crow_t c);
      logic [247:0] f;
      f = '0;
      f[8*8 +: 32] = c.len;
      f[12*8 + 7] = c.dir;
      f[14*8 +: 8] = 8'h10;
      f[15*8 +: 32] = {c.src, c.b2, c.sub, c.sig};
      f[19*8 +: 16] = c.addr;
      f[30*8 +: 8] = c.rsv;
      return f;
   endfunction

   task automatic run_cmd(input bms_crow_t c, input bit gapped);
      host_u.send(mk(c), gapped);
      wait_flag(1'b1);
      chk("op", c.op, cmd.op);
      chk("pass", c.pass, cmd.pass);
      chk("length", (c.len > 32'h0000_00FF) ? 8'h00 : c.len[7:0], cmd.length);
      @(posedge clock);
      #1;
      chk("valid_pulse", 1'b0, cmd.valid);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      errors = 0;
      checks_done = 0;
      rst = 1'b1;
      probe = '0;
      drive_reset_line_n = 1'b1;
      foreach (mrows[i]) begin
         start(mrows[i].pin_n, mrows[i].present, mrows[i].sig);
         chk("mode", mrows[i].exp, mode);
         chk("ids", 48'h0, {usb_vendor_id, usb_product_id, usb_release_id});
         probe.signature = ~probe.signature;
         drive_reset_line_n = ~drive_reset_line_n;
         repeat (4) @(posedge clock);
         chk("mode_held", mrows[i].exp, mode);
      end
      start(1'b0, 1'b1, 16'h1234);
      foreach (crows[i]) begin
         run_cmd(crows[i], i[0]);
         chk("pin_ctl", (crows[i].op == BMS_OP_BOARD) && !crows[i].dir, pin_control_mode);
      end
      run_cmd(crows[0], 1'b0);
      chk("pin_ctl_held", 1'b1, pin_control_mode);
      start(1'b1, 1'b1, 16'h534B);
      chk("pin_ctl_rst", 1'b0, pin_control_mode);
      r = crows[1];
      r.op = BMS_OP_NONE;
      r.pass = 1'b0;
      run_cmd(r, 1'b0);
      finish_test();
   end
endmodule

// [verilog/bms_top.sv]
// Boot mode selector and vendor configuration command decoder
module bms_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Configuration memory probe result
   input wire bms_pkg::bms_probe_t probe,
   // Drive reset line pin, active low
   input wire logic drive_reset_line_n,
   // Command wrapper, one byte per beat, byte 0 first
   input wire logic cbw_valid,
   input wire logic cbw_first,
   input wire logic [7:0] cbw_byte,
   // Mode outputs
   output bms_pkg::bms_mode_t mode,
   output logic mode_valid,
   output logic [15:0] usb_vendor_id,
   output logic [15:0] usb_product_id,
   output logic [15:0] usb_release_id,
   output logic pin_control_mode,
   // Decoded command
   output bms_pkg::bms_cmd_t cmd
);
   import bms_pkg::*;

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   logic reset_line_meta;
   logic reset_line_sync;

   // Two flops before use
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reset_line_meta <= 1'b1;
         reset_line_sync <= 1'b1;
      end else begin
         reset_line_meta <= drive_reset_line_n;
         reset_line_sync <= reset_line_meta;
      end
   end

   // ----------------------------------------
   // Mode decision
   // ----------------------------------------
   bms_state_t state;
   bms_mode_t next_mode;
   logic [7:0] stored_sig;

   // Mode priority: forced test, no memory, signatures, fallback
   always_comb begin
      if (!reset_line_sync) begin
         next_mode = BMS_MODE_TEST;
      end else if (!probe.present) begin
         next_mode = BMS_MODE_NOMEM;
      end else if (probe.signature == BMS_SIG_LEGACY) begin
         next_mode = BMS_MODE_COMPAT;
      end else if (probe.signature == BMS_SIG_CURRENT) begin
         next_mode = BMS_MODE_NORMAL;
      end else begin
         next_mode = BMS_MODE_TEST;
      end
   end

   // Decide once after the probe, then hold
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= BMS_ST_PROBE;
         mode <= BMS_MODE_NOMEM;
         mode_valid <= 1'b0;
         stored_sig <= BMS_ZERO_BYTE;
      end else begin
         unique case (state)
            BMS_ST_PROBE: begin
               if (probe.valid) begin
                  state <= BMS_ST_DECIDE;
               end
            end
            BMS_ST_DECIDE: begin
               mode <= next_mode;
               mode_valid <= 1'b1;
               stored_sig <= probe.cmd_sig;
               state <= BMS_ST_RUN;
            end
            BMS_ST_RUN: begin
               state <= BMS_ST_RUN;
            end
            default: begin
               state <= BMS_ST_PROBE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Descriptor identifiers
   // ----------------------------------------
   // Zero identifiers in every mode; no descriptor path drives them
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         usb_vendor_id <= BMS_ZERO_ID;
         usb_product_id <= BMS_ZERO_ID;
         usb_release_id <= BMS_ZERO_ID;
      end else begin
         usb_vendor_id <= BMS_ZERO_ID;
         usb_product_id <= BMS_ZERO_ID;
         usb_release_id <= BMS_ZERO_ID;
      end
   end

   // ----------------------------------------
   // Wrapper capture
   // ----------------------------------------
   logic [7:0] cbw_mem [BMS_CBW_BYTES];
   logic [4:0] beat;
   logic frame_done;
   logic [4:0] next_beat;

   assign next_beat = cbw_first ? 5'h01 : beat + 5'h01;

   // beat count; frame_done marks the last wrapper byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         beat <= 5'h00;
         frame_done <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         if (cbw_valid) begin
            beat <= next_beat;
            frame_done <= (next_beat == 5'(BMS_CBW_BYTES));
         end
      end
   end

   // Byte storage, one 8-bit register per entry
   genvar gi;
   generate
      for (gi = 0; gi < BMS_CBW_BYTES; gi++) begin : g_byte
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               cbw_mem[gi] <= BMS_ZERO_BYTE;
            end else if (cbw_valid && ((cbw_first ? 5'h00 : beat) == 5'(gi))) begin
               cbw_mem[gi] <= cbw_byte;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic [31:0] xfer_len;
   logic dir_in;
   logic sig_ok;
   logic is_cfg;
   logic is_board;
   logic fields_ok;
   logic rsv_ok;
   logic in_test;

   // length from bytes 8 to 11
   assign xfer_len = {cbw_mem[BMS_LEN_LO + 3], cbw_mem[BMS_LEN_LO + 2],
                      cbw_mem[BMS_LEN_LO + 1], cbw_mem[BMS_LEN_LO]};
   assign dir_in = cbw_mem[BMS_FLAG_BYTE][BMS_DIR_BIT];
   assign sig_ok = cbw_mem[BMS_CB_BASE] == stored_sig;
   assign is_cfg = cbw_mem[BMS_CB_BASE + 1] == BMS_SUB_CFG;
   assign is_board = cbw_mem[BMS_CB_BASE + 1] == BMS_SUB_BOARD;
   // commands accepted only in test mode
   assign in_test = mode_valid && (mode == BMS_MODE_TEST);

   // Reserved bytes 6 to 15 must be zero for a configuration command to pass
   always_comb begin
      rsv_ok = 1'b1;
      for (int i = BMS_RSV_LO; i <= BMS_RSV_HI; i++) begin
         if (cbw_mem[BMS_CB_BASE + i] != BMS_ZERO_BYTE) begin
            rsv_ok = 1'b0;
         end
      end
   end

   assign fields_ok = (cbw_mem[BMS_CB_BASE + 2] == BMS_ZERO_BYTE) &&
                      (cbw_mem[BMS_CB_BASE + 3] == BMS_SRC_EXT_MEM) &&
                      ({cbw_mem[BMS_CB_BASE + 5], cbw_mem[BMS_CB_BASE + 4]} == BMS_START_ADDR) &&
                      rsv_ok;

   // Result one cycle after frame_done, two cycles after the last wrapper byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd <= '0;
      end else begin
         cmd.valid <= frame_done;
         if (frame_done) begin
            if (in_test && sig_ok && is_cfg) begin
               cmd.op <= dir_in ? BMS_OP_CFG_READ : BMS_OP_CFG_LOAD;
               cmd.pass <= fields_ok && (xfer_len <= BMS_MAX_XFER);
               cmd.length <= (xfer_len <= BMS_MAX_XFER) ? xfer_len[7:0] : BMS_ZERO_BYTE;
            end else if (in_test && sig_ok && is_board) begin
               cmd.op <= BMS_OP_BOARD;
               cmd.pass <= 1'b1;
               cmd.length <= (xfer_len <= BMS_MAX_XFER) ? xfer_len[7:0] : BMS_ZERO_BYTE;
            end else begin
               cmd.op <= BMS_OP_NONE;
               cmd.pass <= 1'b0;
               cmd.length <= BMS_ZERO_BYTE;
            end
         end
      end
   end

   // board load latches pin control until reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_control_mode <= 1'b0;
      end else if (frame_done && in_test && sig_ok && is_board && !dir_in) begin
         pin_control_mode <= 1'b1;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Mode decision checks and the no-memory identifier check
   a_mode_held: assert property (@(posedge clock) disable iff (rst)
      $past(mode_valid) |-> $stable(mode)) else $error("mode changed after decision");
   a_force_test: assert property (@(posedge clock) disable iff (rst)
      state == BMS_ST_DECIDE && !reset_line_sync |=> mode == BMS_MODE_TEST) else $error("low line not test");
   a_legacy_mode: assert property (@(posedge clock) disable iff (rst)
      state == BMS_ST_DECIDE && reset_line_sync && probe.present && probe.signature == BMS_SIG_LEGACY
      |=> mode == BMS_MODE_COMPAT) else $error("legacy not compat");
   a_normal_mode: assert property (@(posedge clock) disable iff (rst)
      state == BMS_ST_DECIDE && reset_line_sync && probe.present && probe.signature == BMS_SIG_CURRENT
      |=> mode == BMS_MODE_NORMAL) else $error("current not normal");
   a_nomem_ids: assert property (@(posedge clock) disable iff (rst)
      mode == BMS_MODE_NOMEM |-> usb_vendor_id == BMS_ZERO_ID && usb_product_id == BMS_ZERO_ID)
      else $error("no memory ids not zero");
   a_bad_sig: assert property (@(posedge clock) disable iff (rst)
      state == BMS_ST_DECIDE && reset_line_sync && probe.present && probe.signature != BMS_SIG_LEGACY
      && probe.signature != BMS_SIG_CURRENT |=> mode == BMS_MODE_TEST) else $error("bad sig not test");

   // Command decode checks, then further mode decision checks
   a_cmd_latency: assert property (@(posedge clock) disable iff (rst)
      frame_done |=> cmd.valid) else $error("no result after wrapper");
   a_len_limit: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && is_cfg && xfer_len > BMS_MAX_XFER
      |=> cmd.valid && !cmd.pass && cmd.length == BMS_ZERO_BYTE)
      else $error("length above limit passed");
   a_len_copy: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && is_cfg && xfer_len <= BMS_MAX_XFER
      |=> cmd.length == cbw_mem[BMS_LEN_LO]) else $error("length not taken from wrapper");
   a_fail_sig: assert property (@(posedge clock) disable iff (rst)
      frame_done && !sig_ok |=> cmd.valid && !cmd.pass) else $error("bad signature passed");
   a_dir_read: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && is_cfg && dir_in |=> cmd.op == BMS_OP_CFG_READ)
      else $error("read direction lost");
   a_pin_sticky: assert property (@(posedge clock) disable iff (rst)
      pin_control_mode |=> pin_control_mode) else $error("pin control left");
   a_pin_set: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && is_board && !dir_in |=> pin_control_mode)
      else $error("board load did not enter pin control");
   a_dir_load: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && is_cfg && !dir_in |=> cmd.op == BMS_OP_CFG_LOAD)
      else $error("load direction lost");
   a_board_code: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && is_board |=> cmd.valid && cmd.pass && cmd.op == BMS_OP_BOARD)
      else $error("board command not recognised");
   a_cfg_code: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && !is_cfg && !is_board |=> cmd.op == BMS_OP_NONE && !cmd.pass)
      else $error("unknown subcode accepted");
   a_bad_fields: assert property (@(posedge clock) disable iff (rst)
      frame_done && in_test && sig_ok && is_cfg && !fields_ok |=> cmd.valid && !cmd.pass)
      else $error("bad fields passed");
   a_not_test: assert property (@(posedge clock) disable iff (rst)
      frame_done && !in_test |=> cmd.valid && !cmd.pass && cmd.op == BMS_OP_NONE)
      else $error("command accepted outside test mode");
   a_nomem_mode: assert property (@(posedge clock) disable iff (rst)
      state == BMS_ST_DECIDE && reset_line_sync && !probe.present |=> mode == BMS_MODE_NOMEM)
      else $error("missing memory not flagged");
   a_sig_stored: assert property (@(posedge clock) disable iff (rst)
      state == BMS_ST_DECIDE |=> stored_sig == probe.cmd_sig)
      else $error("stored signature not taken");
   a_valid_held: assert property (@(posedge clock) disable iff (rst)
      mode_valid |=> mode_valid) else $error("mode valid dropped");
   a_run_decided: assert property (@(posedge clock) disable iff (rst)
      state == BMS_ST_RUN |-> mode_valid) else $error("running without decision");

   // Main scenario covers
   c_cfg_read: cover property (@(posedge clock) disable iff (rst) cmd.valid && cmd.op == BMS_OP_CFG_READ);
   c_cfg_load: cover property (@(posedge clock) disable iff (rst) cmd.valid && cmd.op == BMS_OP_CFG_LOAD);
   c_board: cover property (@(posedge clock) disable iff (rst) pin_control_mode);
   c_normal: cover property (@(posedge clock) disable iff (rst) mode_valid && mode == BMS_MODE_NORMAL);
   c_failed: cover property (@(posedge clock) disable iff (rst) cmd.valid && !cmd.pass);
endmodule
